// *** core/bvm_pkg.sv ***
// package for the battery voltage monitor event block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package bvm_pkg;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam logic [31:0] ADDR_CONTROL = 32'h5000004c;
  localparam logic [31:0] ADDR_TRIM    = 32'h50000050;
  localparam logic [31:0] ADDR_DBNC    = 32'h50000054;
  localparam logic [31:0] ADDR_THRES   = 32'h50000058;
  localparam logic [31:0] ADDR_IRQ     = 32'h5000005c;

  // control fields
  localparam int CTL_SURGE_FILT = 27;
  localparam int CTL_SAG_FILT   = 26;
  localparam int CTL_SURGE_RAW  = 25;
  localparam int CTL_SAG_RAW    = 24;
  localparam int CTL_SURGE_INV  = 3;
  localparam int CTL_SAG_INV    = 2;
  localparam int CTL_SURGE_EN   = 1;
  localparam int CTL_SAG_EN     = 0;

  // trim fields
  localparam int TRM_SURGE_HYS = 24;
  localparam int TRM_SURGE_LVL = 16;
  localparam int TRM_SAG_HYS   = 8;
  localparam int TRM_SAG_LVL   = 0;
  localparam logic [3:0] SURGE_LVL_RST = 4'h7;
  localparam logic [3:0] SURGE_LVL_MAX = 4'h9;
  localparam logic [5:0] SAG_LVL_RST   = 6'h09;
  localparam logic [5:0] SAG_LVL_MAX   = 6'h27;
  localparam logic [1:0] HYS_RST       = 2'h1;

  // debounce config fields
  localparam int DBC_SURGE_RSLOW = 5;
  localparam int DBC_SURGE_FSLOW = 4;
  localparam int DBC_SAG_RSLOW   = 3;
  localparam int DBC_SAG_FSLOW   = 2;
  localparam int DBC_SURGE_ON    = 1;
  localparam int DBC_SAG_ON      = 0;
  localparam logic [5:0] DBC_RST = 6'h17;

  // threshold fields
  localparam int THR_SURGE_FALL = 24;
  localparam int THR_SAG_FALL   = 16;
  localparam int THR_SURGE_RISE = 8;
  localparam int THR_SAG_RISE   = 0;
  localparam logic [7:0] FALL_LIM_RST = 8'hff;
  localparam logic [7:0] RISE_LIM_RST = 8'h01;

  // interrupt fields
  localparam int IRQ_SURGE_ACT = 25;
  localparam int IRQ_SAG_ACT   = 24;
  localparam int IRQ_SURGE_ST  = 17;
  localparam int IRQ_SAG_ST    = 16;
  localparam int IRQ_SURGE_CLR = 9;
  localparam int IRQ_SAG_CLR   = 8;
  localparam int IRQ_SURGE_ENA = 1;
  localparam int IRQ_SAG_ENA   = 0;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       rise_slow;
    logic       fall_slow;
    logic [7:0] rise_lim;
    logic [7:0] fall_lim;
  } bvm_dbc_cfg_s;

  typedef struct packed {
    logic [1:0] surge_hysteresis_select;
    logic [3:0] surge_level_trim;
    logic [1:0] sag_hysteresis_select;
    logic [5:0] sag_level_trim;
    logic       surge_comparator_enable;
    logic       sag_comparator_enable;
  } bvm_analog_s;

  typedef enum logic [1:0] {
    BVM_IDLE,
    BVM_COUNT
  } bvm_dbc_e;

endpackage

// *** core/bvm_monitor.sv ***
// battery voltage monitor event logic: filters, status and interrupt unit
`timescale 1ns/100ps
module bvm_monitor (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // debounce tick strobes, one cycle each
  input  wire logic               fast_tick,
  input  wire logic               slow_tick,
  // comparators
  input  wire logic               surge_event,
  input  wire logic               sag_event,
  output bvm_pkg::bvm_analog_s    analog_cfg,
  // register port
  input  wire logic [31:0]        reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // interrupt request
  output logic                    irq
);

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [3:0]  ctl_q;
  logic [1:0]  surge_hys_q;
  logic [3:0]  surge_lvl_q;
  logic [1:0]  sag_hys_q;
  logic [5:0]  sag_lvl_q;
  logic [5:0]  dbc_q;
  logic [31:0] thr_q;
  logic [1:0]  ena_q;
  logic [1:0]  st_q;
  logic [1:0]  raw_q;
  logic [1:0]  filt_q;
  logic [1:0]  out_q;
  logic [7:0]  cnt_q [2];
  logic [31:0] rdata_q;
  logic        irq_q;

  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  wire wr_ctl   = reg_wr && (reg_addr == bvm_pkg::ADDR_CONTROL);
  wire wr_trim  = reg_wr && (reg_addr == bvm_pkg::ADDR_TRIM);
  wire wr_dbc   = reg_wr && (reg_addr == bvm_pkg::ADDR_DBNC);
  wire wr_thr   = reg_wr && (reg_addr == bvm_pkg::ADDR_THRES);
  wire wr_irq   = reg_wr && (reg_addr == bvm_pkg::ADDR_IRQ);
  wire [1:0] clr = wr_irq ? {reg_wdata[bvm_pkg::IRQ_SURGE_CLR],
                             reg_wdata[bvm_pkg::IRQ_SAG_CLR]} : 2'h0;

  // ----------------------------------------------------------------------------
  // debouncers, index 1 surge, index 0 sag
  // ----------------------------------------------------------------------------
  bvm_pkg::bvm_dbc_cfg_s dcfg [2];
  assign dcfg[1] = '{rise_slow: dbc_q[bvm_pkg::DBC_SURGE_RSLOW],
                     fall_slow: dbc_q[bvm_pkg::DBC_SURGE_FSLOW],
                     rise_lim:  thr_q[bvm_pkg::THR_SURGE_RISE +: 8],
                     fall_lim:  thr_q[bvm_pkg::THR_SURGE_FALL +: 8]};
  assign dcfg[0] = '{rise_slow: dbc_q[bvm_pkg::DBC_SAG_RSLOW],
                     fall_slow: dbc_q[bvm_pkg::DBC_SAG_FSLOW],
                     rise_lim:  thr_q[bvm_pkg::THR_SAG_RISE +: 8],
                     fall_lim:  thr_q[bvm_pkg::THR_SAG_FALL +: 8]};

  // the debouncer counts ticks while raw differs from filtered; any glitch back
  // to the filtered level restarts the count, so short spikes never pass
  logic [1:0] tick;
  logic [1:0] chg;
  logic [1:0] done;
  logic [7:0] lim [2];
  logic [7:0] cnt_d [2];
  logic [1:0] filt_d;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      chg[i]   = raw_q[i] != filt_q[i];
      // raw high means a rising request, else falling
      tick[i]  = raw_q[i] ? (dcfg[i].rise_slow ? slow_tick : fast_tick)
                          : (dcfg[i].fall_slow ? slow_tick : fast_tick);
      lim[i]   = raw_q[i] ? dcfg[i].rise_lim : dcfg[i].fall_lim;
      done[i]  = chg[i] && tick[i] && (cnt_q[i] == lim[i]);
      filt_d[i] = done[i] ? raw_q[i] : filt_q[i];
      if (!chg[i] || done[i]) begin
        cnt_d[i] = 8'h00;
      end else if (tick[i]) begin
        cnt_d[i] = cnt_q[i] + 8'h01;
      end else begin
        cnt_d[i] = cnt_q[i];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // event path and interrupt unit
  // ----------------------------------------------------------------------------
  wire [1:0] path = {dbc_q[bvm_pkg::DBC_SURGE_ON] ? filt_q[1] : raw_q[1],
                     dbc_q[bvm_pkg::DBC_SAG_ON]   ? filt_q[0] : raw_q[0]};
  wire [1:0] evt  = path ^ {ctl_q[bvm_pkg::CTL_SURGE_INV], ctl_q[bvm_pkg::CTL_SAG_INV]};
  // set beats clear so an event during a clear write is not lost
  wire [1:0] st_d  = evt | (st_q & ~clr);
  wire [1:0] act   = st_q & ena_q;

  // ----------------------------------------------------------------------------
  // trim forwarding, out-of-range levels fold to zero
  // ----------------------------------------------------------------------------
  function automatic logic [5:0] fold(input logic [5:0] v, input logic [5:0] mx);
    fold = (v > mx) ? 6'h00 : v;
  endfunction
  wire [5:0] surge_trim6 = fold({2'h0, surge_lvl_q}, {2'h0, bvm_pkg::SURGE_LVL_MAX});
  wire [5:0] sag_trim6   = fold(sag_lvl_q, bvm_pkg::SAG_LVL_MAX);
  bvm_pkg::bvm_analog_s analog_d;
  assign analog_d = '{surge_hysteresis_select: surge_hys_q,
                      surge_level_trim:        surge_trim6[3:0],
                      sag_hysteresis_select:   sag_hys_q,
                      sag_level_trim:          sag_trim6,
                      surge_comparator_enable: ctl_q[bvm_pkg::CTL_SURGE_EN],
                      sag_comparator_enable:   ctl_q[bvm_pkg::CTL_SAG_EN]};

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  logic [31:0] rd_ctl;
  logic [31:0] rd_trim;
  logic [31:0] rd_irq;
  always_comb begin
    rd_ctl = 32'h0;
    rd_ctl[bvm_pkg::CTL_SURGE_FILT] = filt_q[1];
    rd_ctl[bvm_pkg::CTL_SAG_FILT]   = filt_q[0];
    rd_ctl[bvm_pkg::CTL_SURGE_RAW]  = raw_q[1];
    rd_ctl[bvm_pkg::CTL_SAG_RAW]    = raw_q[0];
    rd_ctl[3:0] = ctl_q;
    rd_trim = 32'h0;
    rd_trim[bvm_pkg::TRM_SURGE_HYS +: 2] = surge_hys_q;
    rd_trim[bvm_pkg::TRM_SURGE_LVL +: 4] = surge_lvl_q;
    rd_trim[bvm_pkg::TRM_SAG_HYS +: 2]   = sag_hys_q;
    rd_trim[bvm_pkg::TRM_SAG_LVL +: 6]   = sag_lvl_q;
    rd_irq = 32'h0;
    rd_irq[bvm_pkg::IRQ_SURGE_ACT] = act[1];
    rd_irq[bvm_pkg::IRQ_SAG_ACT]   = act[0];
    rd_irq[bvm_pkg::IRQ_SURGE_ST]  = st_q[1];
    rd_irq[bvm_pkg::IRQ_SAG_ST]    = st_q[0];
    rd_irq[bvm_pkg::IRQ_SURGE_ENA] = ena_q[1];
    rd_irq[bvm_pkg::IRQ_SAG_ENA]   = ena_q[0];
  end
  wire [31:0] rd_sel =
    (reg_addr == bvm_pkg::ADDR_CONTROL) ? rd_ctl :
    (reg_addr == bvm_pkg::ADDR_TRIM)    ? rd_trim :
    (reg_addr == bvm_pkg::ADDR_DBNC)    ? {26'h0, dbc_q} :
    (reg_addr == bvm_pkg::ADDR_THRES)   ? thr_q :
    (reg_addr == bvm_pkg::ADDR_IRQ)     ? rd_irq : 32'h0;

  // ----------------------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q       <= 4'h0;
      surge_hys_q <= bvm_pkg::HYS_RST;
      surge_lvl_q <= bvm_pkg::SURGE_LVL_RST;
      sag_hys_q   <= bvm_pkg::HYS_RST;
      sag_lvl_q   <= bvm_pkg::SAG_LVL_RST;
      dbc_q       <= bvm_pkg::DBC_RST;
      thr_q       <= {bvm_pkg::FALL_LIM_RST, bvm_pkg::FALL_LIM_RST,
                      bvm_pkg::RISE_LIM_RST, bvm_pkg::RISE_LIM_RST};
      ena_q       <= 2'h0;
    end else begin
      if (wr_ctl) begin
        ctl_q <= reg_wdata[3:0];
      end
      if (wr_trim) begin
        surge_hys_q <= reg_wdata[bvm_pkg::TRM_SURGE_HYS +: 2];
        surge_lvl_q <= reg_wdata[bvm_pkg::TRM_SURGE_LVL +: 4];
        sag_hys_q   <= reg_wdata[bvm_pkg::TRM_SAG_HYS +: 2];
        sag_lvl_q   <= reg_wdata[bvm_pkg::TRM_SAG_LVL +: 6];
      end
      if (wr_dbc) begin
        dbc_q <= reg_wdata[5:0];
      end
      if (wr_thr) begin
        thr_q <= reg_wdata;
      end
      if (wr_irq) begin
        ena_q <= {reg_wdata[bvm_pkg::IRQ_SURGE_ENA], reg_wdata[bvm_pkg::IRQ_SAG_ENA]};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_q      <= 2'h0;
      filt_q     <= 2'h0;
      cnt_q[0]   <= 8'h00;
      cnt_q[1]   <= 8'h00;
      st_q       <= 2'h0;
      irq_q      <= 1'b0;
      rdata_q    <= 32'h0;
      analog_cfg <= '0;
    end else begin
      raw_q      <= {surge_event, sag_event};
      filt_q     <= filt_d;
      cnt_q[0]   <= cnt_d[0];
      cnt_q[1]   <= cnt_d[1];
      st_q       <= st_d;
      irq_q      <= |(st_d & ena_q);
      rdata_q    <= reg_rd ? rd_sel : 32'h0;
      analog_cfg <= analog_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

endmodule

// *** bench/bvm_monitor_props.sv ***
// assertion checker for the battery monitor event block
`timescale 1ns/100ps
module bvm_monitor_props (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 arst_n,
  // comparator side
  input wire logic                 surge_event,
  input wire logic                 sag_event,
  input wire bvm_pkg::bvm_analog_s analog_cfg,
  // register port
  input wire logic [31:0]          reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata
);
  // ---------------------------------------------------------------------------
  // decodes
  // ---------------------------------------------------------------------------
  wire wr_ctl  = reg_wr && reg_addr == bvm_pkg::ADDR_CONTROL;
  wire wr_trim = reg_wr && reg_addr == bvm_pkg::ADDR_TRIM;
  wire rd_ctl  = reg_rd && reg_addr == bvm_pkg::ADDR_CONTROL;
  wire rd_irq  = reg_rd && reg_addr == bvm_pkg::ADDR_IRQ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  chk_cmp_enable: assert property (wr_ctl |-> ##2
    analog_cfg[1:0] == $past(reg_wdata[1:0], 2)) else $error("comparator enable mismatch");
  chk_hys_fwd: assert property (wr_trim |-> ##2
    {analog_cfg.surge_hysteresis_select, analog_cfg.sag_hysteresis_select}
      == {$past(reg_wdata[25:24], 2), $past(reg_wdata[9:8], 2)}) else $error("hysteresis wrong");
  chk_surge_fold: assert property (wr_trim |-> ##2 analog_cfg.surge_level_trim ==
    ($past(reg_wdata[19:16], 2) > 4'h9 ? 4'h0 : $past(reg_wdata[19:16], 2)))
    else $error("surge trim wrong");
  chk_sag_fold: assert property (wr_trim |-> ##2 analog_cfg.sag_level_trim ==
    ($past(reg_wdata[5:0], 2) > 6'h27 ? 6'h00 : $past(reg_wdata[5:0], 2)))
    else $error("sag trim wrong");
  chk_trim_bound: assert property (analog_cfg.surge_level_trim <= 4'h9
    && analog_cfg.sag_level_trim <= 6'h27) else $error("trim out of range");
  chk_active_and: assert property (rd_irq |=>
    reg_rdata[25:24] == (reg_rdata[17:16] & reg_rdata[1:0])) else $error("active flag wrong");
  chk_clear_zero: assert property (rd_irq |=> reg_rdata[9:8] == 2'h0)
    else $error("clear bits read nonzero");
  chk_raw_status: assert property (rd_ctl |=>
    reg_rdata[25:24] == {$past(surge_event, 2), $past(sag_event, 2)}) else $error("raw wrong");
endmodule

bind bvm_monitor bvm_monitor_props u_bvm_monitor_props (
  .clk(clk), .arst_n(arst_n), .surge_event(surge_event), .sag_event(sag_event),
  .analog_cfg(analog_cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// *** bench/bvm_comparator_model.sv ***
// stand-in for the analog surge and sag comparators
`timescale 1ns/100ps
module bvm_comparator_model (
  // clock
  input  wire logic                 clk,
  // configuration and commanded supply condition
  input  wire bvm_pkg::bvm_analog_s analog_cfg,
  input  wire logic [1:0]           want,
  // raw comparator outputs
  output logic                      surge_event,
  output logic                      sag_event
);
  initial {surge_event, sag_event} = 2'b00;
  // a disabled comparator cannot report, so its output sits low
  always @(posedge clk) begin
    surge_event <= want[1] & analog_cfg.surge_comparator_enable;
    sag_event   <= want[0] & analog_cfg.sag_comparator_enable;
  end
endmodule

// *** bench/bvm_monitor_test.sv ***
// self-checking bench for the battery monitor event block
`timescale 1ns/100ps
module bvm_monitor_test;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} bvm_row_s;
  logic                 clk, arst_n, fast_tick, surge_event, sag_event;
  logic                 slow_tick = 1'b0;
  logic                 reg_wr, reg_rd, irq;
  logic [31:0]          reg_addr, reg_wdata, reg_rdata;
  logic [1:0]           want;
  logic [2:0]           tcnt = 3'h0;
  bvm_pkg::bvm_analog_s analog_cfg;
  int                   n_errors, samples_checked;
  bvm_row_s rows [12] = '{
    '{1'b0, bvm_pkg::ADDR_CONTROL, 32'h0, 32'h0},
    '{1'b0, bvm_pkg::ADDR_TRIM, 32'h0, 32'h01070109},
    '{1'b0, bvm_pkg::ADDR_DBNC, 32'h0, 32'h17},
    '{1'b0, bvm_pkg::ADDR_THRES, 32'h0, 32'hffff0101},
    '{1'b0, bvm_pkg::ADDR_IRQ, 32'h0, 32'h0},
    '{1'b0, 32'h50000060, 32'h0, 32'h0},
    '{1'b1, bvm_pkg::ADDR_TRIM, 32'h030a1228, 32'h030a0228},
    '{1'b1, bvm_pkg::ADDR_IRQ, 32'hffffffff, 32'h3},
    '{1'b1, bvm_pkg::ADDR_CONTROL, 32'h0f000003, 32'h3},
    '{1'b1, 32'h50000060, 32'hffffffff, 32'h0},
    '{1'b1, bvm_pkg::ADDR_THRES, 32'h02010302, 32'h02010302},
    '{1'b1, bvm_pkg::ADDR_DBNC, 32'h0, 32'h0}};

  bvm_monitor u_bvm_monitor (.clk(clk), .arst_n(arst_n), .fast_tick(fast_tick),
    .slow_tick(slow_tick), .surge_event(surge_event), .sag_event(sag_event),
    .analog_cfg(analog_cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  bvm_comparator_model u_bvm_comparator_model (.clk(clk), .analog_cfg(analog_cfg),
    .want(want), .surge_event(surge_event), .sag_event(sag_event));

  // ---------------------------------------------------------------------------
  // clock, slow tick every eighth cycle, watchdog
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    tcnt <= tcnt + 3'h1;
    slow_tick <= (tcnt == 3'h7);
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp("reg_rdata", e, reg_rdata);
  endtask
  task automatic look(input int i, input logic r, input logic f);
    rd(bvm_pkg::ADDR_CONTROL, 32'h3 | (32'(r) << (24 + i)) | (32'(f) << (26 + i)));
  endtask
  // first look is early enough that a correct filter cannot have moved yet
  task automatic step(input int i, input logic up, input int n, input logic slow);
    @(posedge clk);
    want[i] <= up;
    repeat (n) @(posedge clk);
    look(i, up, !up);
    look(i, up, slow ? !up : up);
    if (slow) begin
      repeat (40) @(posedge clk);
      look(i, up, up);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {arst_n, reg_wr, reg_rd, want} = '0;
    {reg_addr, reg_wdata} = '0;
    fast_tick = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rd(rows[k].a, rows[k].e);
    end
    // bypassed surge sets status and raises the request
    @(posedge clk);
    want <= 2'b10;
    repeat (4) @(posedge clk);
    rd(bvm_pkg::ADDR_IRQ, 32'h02020003);
    cmp("irq", 32'h1, {31'h0, irq});
    @(posedge clk);
    want <= 2'b00;
    // the level-set status re-sets until the low level has reached the status logic
    repeat (2) @(posedge clk);
    wr(bvm_pkg::ADDR_IRQ, 32'h203);
    rd(bvm_pkg::ADDR_IRQ, 32'h3);
    cmp("irq", 32'h0, {31'h0, irq});
    // masked sag source keeps status but stays inactive
    wr(bvm_pkg::ADDR_IRQ, 32'h0);
    want <= 2'b01;
    repeat (4) @(posedge clk);
    rd(bvm_pkg::ADDR_IRQ, 32'h00010000);
    cmp("irq", 32'h0, {31'h0, irq});
    want <= 2'b00;
    wr(bvm_pkg::ADDR_IRQ, 32'h103);
    // inverted polarity turns quiet comparators into events
    wr(bvm_pkg::ADDR_CONTROL, 32'hf);
    repeat (4) @(posedge clk);
    rd(bvm_pkg::ADDR_IRQ, 32'h03030003);
    wr(bvm_pkg::ADDR_CONTROL, 32'h3);
    wr(bvm_pkg::ADDR_IRQ, 32'h303);
    rd(bvm_pkg::ADDR_IRQ, 32'h3);
    // debounced paths on the fast tick, then slow rise and slow fall
    wr(bvm_pkg::ADDR_DBNC, 32'h03);
    step(1, 1'b1, 3, 1'b0);
    step(1, 1'b0, 2, 1'b0);
    step(0, 1'b1, 2, 1'b0);
    step(0, 1'b0, 1, 1'b0);
    wr(bvm_pkg::ADDR_DBNC, 32'h0b);
    step(0, 1'b1, 2, 1'b1);
    wr(bvm_pkg::ADDR_DBNC, 32'h07);
    step(0, 1'b0, 1, 1'b1);
    give_verdict();
  end
endmodule
